// File: audio_out_pkg.sv
`default_nettype none
package audio_out_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_WORD_VALUE_OFS = 8'h00;
   localparam logic [7:0] CTRL_POSITION_OFS = 8'h04;
   localparam logic [7:0] OUTPUT_CONTROL_OFS = 8'h08;
   localparam logic [7:0] OUTPUT_STATUS_OFS = 8'h0c;
   localparam logic [7:0] FRAME_LENGTH_OFS = 8'h10;
   localparam logic [7:0] SAMPLE_POSITION_OFS = 8'h14;
   // output_control_reg fields
   localparam int TRANS_ENABLE_BIT = 0;
   localparam int FIRST_CTRL_EN_BIT = 1;
   localparam int SECOND_CTRL_EN_BIT = 2;
   localparam int BIT_ORDER_BIT = 3;
   localparam int WORD32_BIT = 4;
   localparam int POLARITY_BIT = 6;
   localparam int WORD_SELECT_PULSE_MODE_BIT = 7;
   localparam int STOP_LSB = 8;
   localparam int CTRL_W = 13;
   localparam logic [12:0] CTRL_RESET = 13'h0000;
   // position fields
   localparam int POS_W = 9;
   localparam int SECOND_POS_LSB = 16;
   localparam logic [8:0] POS_RESET = 9'h000;
   localparam logic [8:0] DIVIDER_RESET = 9'h03f;
   // word geometry
   localparam logic [4:0] TOP_BIT_16 = 5'h0f;
   localparam logic [4:0] TOP_BIT_32 = 5'h1f;
   localparam int CTRL_WORD_W = 16;
   localparam logic [4:0] CTRL_TOP_BIT = 5'h0f;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int BIT_CLOCK_PERIOD_NS = 80;
   localparam int HALF_BIT_CYCLES = BIT_CLOCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   typedef enum logic [2:0] {
      SRC_NONE,
      SRC_LEFT,
      SRC_RIGHT,
      SRC_FIRST_CTRL,
      SRC_SECOND_CTRL
   } field_src_t;
endpackage : audio_out_pkg
`default_nettype wire

// File: bit_clock_gen.sv
`default_nettype none
module bit_clock_gen #(
   parameter int HALF_CYCLES = audio_out_pkg::HALF_BIT_CYCLES
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // bit clock
   output logic sck_out,
   output logic fall_tick_out
);
   typedef struct packed {
      logic [15:0] cnt;
      logic sck;
   } gen_state_t;

   localparam logic [15:0] LAST = 16'(HALF_CYCLES - 1);

   gen_state_t q, d;

   if (HALF_CYCLES < 1 || HALF_CYCLES > 65535) begin : g_half_check
      $error("bit_clock_gen: HALF_CYCLES out of range");
   end

   always_comb begin
      d = q;
      if (q.cnt == LAST) begin
         d.cnt = 16'h0000;
         d.sck = ~q.sck;
      end else begin
         d.cnt = q.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         q <= '0;
      end else if (ce_in) begin
         q <= d;
      end
   end

   assign sck_out = q.sck;
   // falling edge of the bit clock is due at this clock edge
   assign fall_tick_out = ce_in && q.sck && (q.cnt == LAST);
endmodule : bit_clock_gen
`default_nettype wire

// File: audio_out_frame_assembler.sv
// Contract
// - send sample bits top bit down to stop index, or stop index up to top
// - frame bits outside every active field go out as zero
// - polarity 0: falling word select edge marks frame start
// - frame length in bit clocks equals divider value plus one
// - each frame may carry two 16-bit control words from one register
// - each control word has its own enable, reset to disabled
// - each control word has a start position field, reset to zero
// - control words follow the same bit order as samples
// - writing a control pair fills a buffer and sets pending flag
// - pending clears once both words are copied into the shadow
// - without new writes the shadowed words repeat in every frame
// - no interrupt for control transfer, only polling of pending
// - fields starting on one bit: left, right, first, second control
// - a field starting inside another cuts off the earlier field
// - frames keep running while transmission is disabled
// - order select 0 msb first from start position, 1 lsb first
// - left and right start positions, both reset to zero
//
// Added by the designer: the register addresses and the strobed register port.
`default_nettype none
module audio_out_frame_assembler #(
   parameter int HALF_CYCLES = audio_out_pkg::HALF_BIT_CYCLES
) (
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [31:0] reg_rdata_out,
   // samples
   input wire logic [31:0] left_sample_in,
   input wire logic [31:0] right_sample_in,
   output logic sample_take_out,
   // serial link
   output logic bit_clock_out,
   output logic word_select_out,
   output logic serial_data_out
);
   typedef struct packed {
      logic [8:0] idx;
      audio_out_pkg::field_src_t fld;
      logic [8:0] off;
      logic sd;
      logic ws;
      logic take;
      logic [31:0] left;
      logic [31:0] right;
      logic [15:0] cw1_buf;
      logic [15:0] cw2_buf;
      logic [15:0] cw1;
      logic [15:0] cw2;
      logic pending;
      logic [12:0] ctl;
      logic [8:0] div;
      logic [8:0] first_control_start_bit;
      logic [8:0] second_control_start_bit;
      logic [8:0] lpos;
      logic [8:0] rpos;
      logic [31:0] rdata;
   } state_t;

   state_t q, d;
   logic sck_w;
   logic tick_w;

   if (HALF_CYCLES < 1) begin : g_half_check
      $error("audio_out_frame_assembler: HALF_CYCLES below one");
   end

   bit_clock_gen #(
      .HALF_CYCLES(HALF_CYCLES)
   ) u_bit_clock_gen (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .sck_out(sck_w),
      .fall_tick_out(tick_w)
   );

   // number of bits a field sends
   function automatic logic [8:0] field_len(input logic [4:0] top, input logic [4:0] lo);
      if (lo > top) begin
         field_len = 9'h000;
      end else begin
         field_len = 9'({4'h0, top - lo} + 9'h001);
      end
   endfunction : field_len

   // bit of a word for a given offset into its field
   function automatic logic pick_bit(input logic [31:0] word, input logic [4:0] top,
                                     input logic [4:0] lo, input logic [8:0] off,
                                     input logic lsb_first);
      logic [4:0] bidx;
      bidx = lsb_first ? 5'(lo + off[4:0]) : 5'(top - off[4:0]);
      pick_bit = word[bidx];
   endfunction : pick_bit

   logic frame_start;
   logic lsb_first;
   logic [4:0] top_bit;
   logic [4:0] stop_bit;
   logic [31:0] left_eff;
   logic [31:0] right_eff;
   logic [15:0] cw1_eff;
   logic [15:0] cw2_eff;
   audio_out_pkg::field_src_t fld_n;
   logic [8:0] off_n;
   logic [8:0] len_n;
   logic bit_n;
   logic ws_n;
   logic en_first;
   logic en_second;

   always_comb begin
      d = q;
      frame_start = (q.idx == 9'h000);
      lsb_first = q.ctl[audio_out_pkg::BIT_ORDER_BIT];
      top_bit = q.ctl[audio_out_pkg::WORD32_BIT] ? audio_out_pkg::TOP_BIT_32
                                                 : audio_out_pkg::TOP_BIT_16;
      stop_bit = q.ctl[audio_out_pkg::STOP_LSB +: 5];
      if (!q.ctl[audio_out_pkg::WORD32_BIT]) begin
         stop_bit[4] = 1'b0;
      end
      en_first = q.ctl[audio_out_pkg::FIRST_CTRL_EN_BIT];
      en_second = q.ctl[audio_out_pkg::SECOND_CTRL_EN_BIT];
      // new samples and control words take effect at bit 0
      left_eff = q.left;
      right_eff = q.right;
      cw1_eff = q.cw1;
      cw2_eff = q.cw2;
      if (frame_start) begin
         left_eff = q.ctl[audio_out_pkg::TRANS_ENABLE_BIT] ? left_sample_in : 32'h0000_0000;
         right_eff = q.ctl[audio_out_pkg::TRANS_ENABLE_BIT] ? right_sample_in : 32'h0000_0000;
         if (q.pending) begin
            cw1_eff = q.cw1_buf;
            cw2_eff = q.cw2_buf;
         end
      end
      // field selection for the bit at idx
      fld_n = frame_start ? audio_out_pkg::SRC_NONE : q.fld;
      off_n = q.off + 9'h001;
      if (q.idx == q.lpos) begin
         fld_n = audio_out_pkg::SRC_LEFT;
         off_n = 9'h000;
      end else if (q.idx == q.rpos) begin
         fld_n = audio_out_pkg::SRC_RIGHT;
         off_n = 9'h000;
      end else if (en_first && q.idx == q.first_control_start_bit) begin
         fld_n = audio_out_pkg::SRC_FIRST_CTRL;
         off_n = 9'h000;
      end else if (en_second && q.idx == q.second_control_start_bit) begin
         fld_n = audio_out_pkg::SRC_SECOND_CTRL;
         off_n = 9'h000;
      end
      case (fld_n)
         audio_out_pkg::SRC_LEFT: begin
            len_n = field_len(top_bit, stop_bit);
            bit_n = pick_bit(left_eff, top_bit, stop_bit, off_n, lsb_first);
         end
         audio_out_pkg::SRC_RIGHT: begin
            len_n = field_len(top_bit, stop_bit);
            bit_n = pick_bit(right_eff, top_bit, stop_bit, off_n, lsb_first);
         end
         audio_out_pkg::SRC_FIRST_CTRL: begin
            len_n = en_first ? 9'(audio_out_pkg::CTRL_WORD_W) : 9'h000;
            bit_n = pick_bit({16'h0000, cw1_eff}, audio_out_pkg::CTRL_TOP_BIT, 5'h00,
                             off_n, lsb_first);
         end
         audio_out_pkg::SRC_SECOND_CTRL: begin
            len_n = en_second ? 9'(audio_out_pkg::CTRL_WORD_W) : 9'h000;
            bit_n = pick_bit({16'h0000, cw2_eff}, audio_out_pkg::CTRL_TOP_BIT, 5'h00,
                             off_n, lsb_first);
         end
         default: begin
            len_n = 9'h000;
            bit_n = 1'b0;
         end
      endcase
      if (off_n >= len_n) begin
         fld_n = audio_out_pkg::SRC_NONE;
         bit_n = 1'b0;
      end
      // word select: low at frame start for polarity 0
      if (q.ctl[audio_out_pkg::WORD_SELECT_PULSE_MODE_BIT]) begin
         ws_n = !frame_start;
      end else begin
         ws_n = (q.idx > {1'b0, q.div[8:1]});
      end
      ws_n = ws_n ^ q.ctl[audio_out_pkg::POLARITY_BIT];
      d.take = 1'b0;
      // frames run whatever the transmission enable says
      if (tick_w) begin
         d.sd = bit_n;
         d.ws = ws_n;
         d.fld = fld_n;
         d.off = off_n;
         d.idx = (q.idx >= q.div) ? 9'h000 : q.idx + 9'h001;
         if (frame_start) begin
            d.left = left_eff;
            d.right = right_eff;
            d.take = q.ctl[audio_out_pkg::TRANS_ENABLE_BIT];
            d.cw1 = cw1_eff;
            d.cw2 = cw2_eff;
            d.pending = 1'b0;
         end
      end
      // register port; no interrupt exists for control transfer
      d.rdata = 32'h0000_0000;
      if (reg_read_in) begin
         if (reg_addr_in == audio_out_pkg::CTRL_WORD_VALUE_OFS) begin
            d.rdata = {q.cw2_buf, q.cw1_buf};
         end else if (reg_addr_in == audio_out_pkg::CTRL_POSITION_OFS) begin
            d.rdata = {7'h00, q.second_control_start_bit, 7'h00, q.first_control_start_bit};
         end else if (reg_addr_in == audio_out_pkg::OUTPUT_CONTROL_OFS) begin
            d.rdata = {19'h00000, q.ctl};
         end else if (reg_addr_in == audio_out_pkg::OUTPUT_STATUS_OFS) begin
            d.rdata = {31'h0000_0000, q.pending};
         end else if (reg_addr_in == audio_out_pkg::FRAME_LENGTH_OFS) begin
            d.rdata = {23'h000000, q.div};
         end else if (reg_addr_in == audio_out_pkg::SAMPLE_POSITION_OFS) begin
            d.rdata = {7'h00, q.rpos, 7'h00, q.lpos};
         end
      end
      if (reg_write_in) begin
         if (reg_addr_in == audio_out_pkg::CTRL_WORD_VALUE_OFS) begin
            d.cw1_buf = reg_wdata_in[15:0];
            d.cw2_buf = reg_wdata_in[31:16];
            d.pending = 1'b1;
         end else if (reg_addr_in == audio_out_pkg::CTRL_POSITION_OFS) begin
            d.first_control_start_bit = reg_wdata_in[8:0];
            d.second_control_start_bit = reg_wdata_in[audio_out_pkg::SECOND_POS_LSB +: 9];
         end else if (reg_addr_in == audio_out_pkg::OUTPUT_CONTROL_OFS) begin
            d.ctl = reg_wdata_in[12:0];
         end else if (reg_addr_in == audio_out_pkg::FRAME_LENGTH_OFS) begin
            d.div = reg_wdata_in[8:0];
         end else if (reg_addr_in == audio_out_pkg::SAMPLE_POSITION_OFS) begin
            d.lpos = reg_wdata_in[8:0];
            d.rpos = reg_wdata_in[audio_out_pkg::SECOND_POS_LSB +: 9];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         q <= '0;
         q.fld <= audio_out_pkg::SRC_NONE;
         q.ctl <= audio_out_pkg::CTRL_RESET;
         q.div <= audio_out_pkg::DIVIDER_RESET;
         q.first_control_start_bit <= audio_out_pkg::POS_RESET;
         q.second_control_start_bit <= audio_out_pkg::POS_RESET;
         q.lpos <= audio_out_pkg::POS_RESET;
         q.rpos <= audio_out_pkg::POS_RESET;
      end else if (ce_in) begin
         q <= d;
      end
   end

   assign reg_rdata_out = q.rdata;
   assign sample_take_out = q.take;
   // bit clock straight from the generator flop, so data moves on its fall
   assign bit_clock_out = sck_w;
   assign word_select_out = q.ws;
   assign serial_data_out = q.sd;
endmodule : audio_out_frame_assembler
`default_nettype wire

// File: audio_out_frame_assembler_assertions.sv
`default_nettype none
module audio_out_frame_assembler_assertions #(
   parameter int HALF_CYCLES = 4
) (
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   input wire logic [31:0] reg_rdata_out,
   // link and samples
   input wire logic sample_take_out,
   input wire logic bit_clock_out,
   input wire logic word_select_out,
   input wire logic serial_data_out
);
   localparam int GAP_MAX = 1024 * HALF_CYCLES + 4;
   logic [12:0] ctl_q;
   logic [8:0] div_q;
   logic [1:0] seen_q;
   logic untouched_q;
   logic ws_q;
   logic [9:0] bc_q;
   logic [15:0] gap_q;
   logic ws_fall;
   assign ws_fall = ws_q && !word_select_out;
   // snooped control settings and frame counters
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ctl_q <= 13'h0000;
         div_q <= 9'h03f;
         seen_q <= 2'h0;
         untouched_q <= 1'b1;
         ws_q <= 1'b0;
         bc_q <= 10'h000;
         gap_q <= 16'h0000;
      end else begin
         if (reg_write_in && reg_addr_in == 8'h08) begin
            ctl_q <= reg_wdata_in[12:0];
            untouched_q <= 1'b0;
         end
         if (reg_write_in && reg_addr_in == 8'h10) begin
            div_q <= reg_wdata_in[8:0];
         end
         // a settings write may cause a false word select fall mid-frame
         if (reg_write_in && (reg_addr_in == 8'h10 || reg_addr_in == 8'h08)) begin
            seen_q <= 2'h0;
         end else if (ws_fall && seen_q != 2'h2) begin
            seen_q <= seen_q + 2'h1;
         end
         ws_q <= word_select_out;
         bc_q <= ws_fall ? 10'h001 : bc_q + {9'h000, $fell(bit_clock_out)};
         gap_q <= ws_fall ? 16'h0000 : gap_q + {15'h0000, ce_in};
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence status_read;
      reg_read_in && reg_addr_in == 8'h0c;
   endsequence
   a_read_idle: assert property (!reg_read_in |=> reg_rdata_out == 32'h0)
      else $error("read data not zero outside read answer");
   a_status_upper: assert property (status_read |=> reg_rdata_out[31:1] == 31'h0)
      else $error("status has flags beyond pending");
   a_data_edge: assert property ($changed(serial_data_out) |-> $fell(bit_clock_out))
      else $error("serial data moved off bit clock fall");
   a_ws_edge: assert property ($changed(word_select_out) |-> $fell(bit_clock_out))
      else $error("word select moved off bit clock fall");
   a_frame_length: assert property (ws_fall && seen_q == 2'h2 |->
      bc_q == {1'b0, div_q} + 10'h001)
      else $error("frame length not divider plus one");
   a_take_start: assert property (sample_take_out && !$past(ctl_q[6]) |-> ws_fall)
      else $error("samples taken away from frame start");
   a_take_enabled: assert property (sample_take_out |-> $past(ctl_q[0]))
      else $error("samples taken while disabled");
   a_idle_zero: assert property (untouched_q |-> !serial_data_out)
      else $error("data sent with all fields off");
   a_frames_run: assert property (gap_q < GAP_MAX)
      else $error("frames stopped");
endmodule : audio_out_frame_assembler_assertions
bind audio_out_frame_assembler audio_out_frame_assembler_assertions #(
   .HALF_CYCLES(HALF_CYCLES)
) i_checker (
   .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
   .reg_rdata_out(reg_rdata_out), .sample_take_out(sample_take_out),
   .bit_clock_out(bit_clock_out), .word_select_out(word_select_out),
   .serial_data_out(serial_data_out)
);
`default_nettype wire

// File: dac_frame_capture.sv
`default_nettype none
module dac_frame_capture (
   // serial link
   input wire logic bit_clock_in,
   input wire logic word_select_in,
   input wire logic serial_data_in,
   // captured frame
   output logic [63:0] frame_out,
   output logic [9:0] length_out,
   output logic [15:0] frame_count_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [63:0] bits_q;
   logic [9:0] idx_q;
   logic ws_q;
   initial begin
      frame_out = '0;
      length_out = '0;
      frame_count_out = '0;
      bits_q = '0;
      idx_q = '0;
      ws_q = 1'b0;
   end
   // samples on rising bit clock, frame starts at word select fall
   always @(posedge bit_clock_in) begin
      if (ws_q && !word_select_in) begin
         frame_out = bits_q;
         length_out = idx_q;
         frame_count_out++;
         bits_q = '0;
         idx_q = '0;
      end
      if (idx_q < 10'd64) bits_q[idx_q[5:0]] = serial_data_in;
      idx_q++;
      ws_q = word_select_in;
   end
endmodule : dac_frame_capture
`default_nettype wire

// File: audio_out_frame_assembler_bench.sv
`default_nettype none
module audio_out_frame_assembler_bench;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin failures++; \
   $display("ERROR %s expected %h seen %h", what, exp, got); end end
   logic clk_in, rst_in, ce_in, reg_write, reg_read, take, bck, ws, sd;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rdata, lsmp, rsmp, cw;
   logic [63:0] frame;
   logic [9:0] frame_len;
   logic [15:0] frame_count;
   int failures, check_count;
   logic [12:0] cfg_ctl [5] = '{13'h0001, 13'h041f, 13'h0017, 13'h0007, 13'h0089};
   logic [31:0] cfg_spos [5] = '{32'h0020_0000, 32'h0020_0000, 32'h0014_0000,
                                 32'h0028_0000, 32'h0010_0000};
   logic [31:0] cfg_cpos [5] = '{32'h0, 32'h0030_0010, 32'h0014_0014, 32'h0038_0038, 32'h0};
   logic [8:0] cfg_div [5] = '{9'h03f, 9'h03f, 9'h028, 9'h03f, 9'h01f};
   audio_out_frame_assembler #(.HALF_CYCLES(1)) i_audio_out_frame_assembler (
      .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_write_in(reg_write), .reg_read_in(reg_read),
      .reg_rdata_out(reg_rdata), .left_sample_in(lsmp), .right_sample_in(rsmp),
      .sample_take_out(take), .bit_clock_out(bck), .word_select_out(ws), .serial_data_out(sd)
   );
   dac_frame_capture i_dac_frame_capture (
      .bit_clock_in(bck), .word_select_in(ws), .serial_data_in(sd),
      .frame_out(frame), .length_out(frame_len), .frame_count_out(frame_count)
   );
   // reference frame: fields in rising priority, later start wins
   function automatic logic [63:0] exp_frame(input logic [12:0] c, input logic [31:0] sp, cp,
                                             input logic [8:0] dv);
      logic [63:0] f;
      logic [31:0] w;
      int src, off, top, stop, tp, bp;
      f = '0;
      src = 0;
      off = 0;
      top = c[4] ? 31 : 15;
      stop = c[4] ? int'(c[12:8]) : int'(c[11:8]);
      for (int i = 0; i <= int'(dv); i++) begin
         if (c[2] && int'(cp[24:16]) == i) begin src = 4; off = 0; end
         if (c[1] && int'(cp[8:0]) == i) begin src = 3; off = 0; end
         if (int'(sp[24:16]) == i) begin src = 2; off = 0; end
         if (int'(sp[8:0]) == i) begin src = 1; off = 0; end
         w = src == 1 ? (c[0] ? lsmp : 32'h0) : src == 2 ? (c[0] ? rsmp : 32'h0) :
             src == 3 ? {16'h0, cw[15:0]} : {16'h0, cw[31:16]};
         tp = src > 2 ? 15 : top;
         bp = src > 2 ? 0 : stop;
         if (src != 0 && bp + off <= tp) f[i] = c[3] ? w[bp + off] : w[tp - off];
         else src = 0;
         off++;
      end
      return f;
   endfunction : exp_frame
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_in);
      reg_write <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_in);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_in);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask : reg_rd
   task automatic check_frame(input logic [12:0] c, input logic [31:0] sp, cp,
                              input logic [8:0] dv);
      logic [15:0] start;
      // skip a frame start that raced the last settings write
      repeat (2) @(posedge clk_in);
      start = frame_count;
      for (int n = 0; n < 3000 && frame_count - start < 16'h0002; n++) @(posedge clk_in);
      `CHK("frames seen", 1'b1, frame_count - start >= 16'h0002)
      `CHK("frame", exp_frame(c, sp, cp, dv), frame)
      `CHK("frame length", {1'b0, dv} + 10'h001, frame_len)
   endtask : check_frame
   task automatic report_and_stop();
      if (failures == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   initial begin
      #400000;
      failures++;
      report_and_stop();
   end
   initial begin
      rst_in = 1'b1;
      ce_in = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      lsmp = 32'h8123_a5c3;
      rsmp = 32'h4e6d_1b97;
      cw = 32'h5a3c_c3a5;
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      reg_rd(8'h08, rdata);
      `CHK("control reset", 32'h0, rdata)
      reg_rd(8'h04, rdata);
      `CHK("control positions reset", 32'h0, rdata)
      reg_rd(8'h14, rdata);
      `CHK("sample positions reset", 32'h0, rdata)
      reg_rd(8'h10, rdata);
      `CHK("divider reset", 32'h3f, rdata)
      reg_rd(8'h0c, rdata);
      `CHK("status reset", 32'h0, rdata)
      reg_rd(8'h20, rdata);
      `CHK("unmapped read", 32'h0, rdata)
      check_frame(13'h0000, 32'h0, 32'h0, 9'h03f);
      reg_wr(8'h08, 32'h1);
      for (int n = 0; n < 300 && take !== 1'b1; n++) @(posedge clk_in);
      `CHK("sample take", 1'b1, take)
      reg_wr(8'h00, cw);
      reg_rd(8'h0c, rdata);
      `CHK("pending set", 1'b1, rdata[0])
      for (int n = 0; n < 400 && rdata[0] !== 1'b0; n++) reg_rd(8'h0c, rdata);
      `CHK("pending clear", 1'b0, rdata[0])
      for (int k = 0; k < 5; k++) begin
         reg_wr(8'h08, {19'h0, cfg_ctl[k]});
         reg_wr(8'h14, cfg_spos[k]);
         reg_wr(8'h04, cfg_cpos[k]);
         reg_wr(8'h10, {23'h0, cfg_div[k]});
         check_frame(cfg_ctl[k], cfg_spos[k], cfg_cpos[k], cfg_div[k]);
         check_frame(cfg_ctl[k], cfg_spos[k], cfg_cpos[k], cfg_div[k]);
      end
      report_and_stop();
   end
endmodule : audio_out_frame_assembler_bench
`default_nettype wire
